// [logic/ftr_defs.svh]
// Purpose: Named constants for the fault trace and history recorder.
// Assumes: AHB-Lite word registers; byte address is four times the index.
// Notes:   Register index is taken from haddr[13:2].
//
// Contract
// - Read-only register shows presently active fault code
// - Read-only register keeps most recent recorded fault
// - Latch speed reference at fault, 0.01 percent
// - Latch output and motor speed, same resolution
// - Latch output current, resolution per model constant
// - Latch output voltage and bus voltage
// - Latch output power and torque reference
// - Latch terminal and status words, live layout
// - Latch cumulative operating hours at fault
// - Latch soft starter, q and d currents
// - Latch heatsink temperature at most recent fault
// - Hold peak current and its output frequency
// - Ten history entries, eleventh drops the oldest
// - Newest code in first slot, then by age
// - Shift entries older before writing new code
// - Hours kept and shifted with four newest
// - First four codes at two ranges, rest follow
// - Speed values scaled by display unit setting
// - Status word carries eight individual drive flags
`ifndef FTR_DEFS_SVH
`define FTR_DEFS_SVH

// Register indices
`define FTR_IDX_ACTIVE      12'h080
`define FTR_IDX_LAST        12'h081
`define FTR_IDX_SPD_REF     12'h082
`define FTR_IDX_OUT_SPD     12'h083
`define FTR_IDX_OUT_CUR     12'h084
`define FTR_IDX_MOT_SPD     12'h085
`define FTR_IDX_OUT_VOLT    12'h086
`define FTR_IDX_BUS_VOLT    12'h087
`define FTR_IDX_OUT_PWR     12'h088
`define FTR_IDX_TRQ_REF     12'h089
`define FTR_IDX_IN_TERM     12'h08a
`define FTR_IDX_OUT_TERM    12'h08b
`define FTR_IDX_DRV_STATE   12'h08c
`define FTR_IDX_OP_HOURS    12'h08d
`define FTR_IDX_HEATSINK    12'h08e
`define FTR_IDX_HIST_A_LO   12'h090
`define FTR_IDX_HIST_A_HI   12'h093
`define FTR_IDX_HRS_A_LO    12'h094
`define FTR_IDX_HRS_A_HI    12'h097
`define FTR_IDX_SOFT_START  12'h7e0
`define FTR_IDX_Q_CUR       12'h7e1
`define FTR_IDX_D_CUR       12'h7e2
`define FTR_IDX_PEAK_CUR    12'h7e6
`define FTR_IDX_PEAK_FREQ   12'h7e7
`define FTR_IDX_CTRL        12'h7f0
`define FTR_IDX_SCALE_MPS   12'h7f1
`define FTR_IDX_SCALE_FPM   12'h7f2
`define FTR_IDX_STATUS      12'h7f3
`define FTR_IDX_HIST_B_LO   12'h800
`define FTR_IDX_HIST_B_HI   12'h809
`define FTR_IDX_HRS_B_LO    12'h80a
`define FTR_IDX_HRS_B_HI    12'h80d

// Address slicing
`define FTR_IDX_MSB         13
`define FTR_IDX_LSB         2

// History depths
`define FTR_HIST_DEPTH      10
`define FTR_HRS_DEPTH       4
`define FTR_CNT_W           4
`define FTR_HIST_FULL       4'ha

// Display unit codes and scaling
`define FTR_UNIT_HZ         3'h0
`define FTR_UNIT_MPS_A      3'h4
`define FTR_UNIT_MPS_B      3'h5
`define FTR_UNIT_FPM        3'h6
`define FTR_UNIT_RESET      3'h0
`define FTR_SCALE_RESET     16'h8000
`define FTR_SCALE_MSB       30
`define FTR_SCALE_LSB       15

// Coarse current divisor, 0.01 A to 0.1 A
`define FTR_CUR_DIV         16'h000a

// Drive status word bit positions
`define FTR_ST_RUN          0
`define FTR_ST_ZERO_SPD     1
`define FTR_ST_DOWN         2
`define FTR_ST_RST_IN       3
`define FTR_ST_SPD_AGREE    4
`define FTR_ST_READY        5
`define FTR_ST_ALARM        6
`define FTR_ST_FAULT        7

// Misc reset values
`define FTR_WORD_RESET      16'h0000
`define FTR_BUS_ZERO        32'h0000_0000
`define FTR_HTRANS_NONSEQ   1

`endif

// [logic/ftr_pkg.sv]
// Purpose: Types for the fault trace and history recorder.
// Assumes: All drive quantities arrive as 16-bit words.
// Notes:   Constants live in ftr_defs.svh.
`default_nettype none

package ftr_pkg;

    typedef logic [15:0] ftr_word_t;

    // Individual drive flags that make up the status word
    typedef struct packed {
        logic running;
        logic zero_speed;
        logic down_dir;
        logic reset_input;
        logic speed_agree;
        logic ready;
        logic alarm;
        logic fault;
    } ftr_flags_s;

    // Live drive quantities, sampled at a fault
    typedef struct packed {
        ftr_word_t  speed_ref;
        ftr_word_t  out_speed;
        ftr_word_t  out_current;
        ftr_word_t  motor_speed;
        ftr_word_t  out_voltage;
        ftr_word_t  bus_voltage;
        ftr_word_t  out_power;
        ftr_word_t  torque_ref;
        ftr_word_t  in_terms;
        ftr_word_t  out_terms;
        ftr_word_t  op_hours;
        ftr_word_t  heatsink;
        ftr_word_t  soft_start;
        ftr_word_t  q_current;
        ftr_word_t  d_current;
        ftr_word_t  out_freq;
        ftr_flags_s flags;
    } ftr_live_s;

    // Frozen snapshot of one fault
    typedef struct packed {
        ftr_word_t speed_ref;
        ftr_word_t out_speed;
        ftr_word_t out_current;
        ftr_word_t motor_speed;
        ftr_word_t out_voltage;
        ftr_word_t bus_voltage;
        ftr_word_t out_power;
        ftr_word_t torque_ref;
        ftr_word_t in_terms;
        ftr_word_t out_terms;
        ftr_word_t drive_state;
        ftr_word_t op_hours;
        ftr_word_t heatsink;
        ftr_word_t soft_start;
        ftr_word_t q_current;
        ftr_word_t d_current;
        ftr_word_t peak_current;
        ftr_word_t peak_freq;
    } ftr_snap_s;

endpackage : ftr_pkg

`default_nettype wire

// [logic/ftr_recorder.sv]
// Purpose: Fault trace snapshot and ten-deep fault history, read over AHB-Lite.
// Assumes: Drive inputs are synchronous to hclk; single word transfers only.
// Notes:   Zero wait states; hrdata comes from a flop loaded in the address phase.
`include "ftr_defs.svh"
`default_nettype none

module ftr_recorder #(
    parameter logic COARSE_CURRENT = 1'b0
) (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Fault source
    input  wire logic              fault_active,
    input  wire logic [15:0]       fault_code,
    input  wire logic              ride_start,
    // Live drive quantities
    input  wire ftr_pkg::ftr_live_s live,
    // Observation
    output logic                   fault_capture
);

    // Bus phase state
    logic                  wr_pend_q;
    logic [11:0]           wr_idx_q;
    logic [31:0]           rdata_q;
    logic [11:0]           a_idx;
    logic                  a_valid;

    // Control registers
    logic [2:0]            unit_sel_q;
    logic [15:0]           scale_mps_q;
    logic [15:0]           scale_fpm_q;

    // Fault state
    logic                  fault_prev_q;
    logic                  capture;
    logic [15:0]           active_code_q;
    logic [15:0]           last_code_q;
    logic [`FTR_CNT_W-1:0] hist_cnt_q;
    logic [15:0]           hist_code_q [`FTR_HIST_DEPTH];
    logic [15:0]           hist_hrs_q  [`FTR_HRS_DEPTH];

    // Snapshot and peak hold
    ftr_pkg::ftr_snap_s    snap_q;
    logic [15:0]           peak_cur_q;
    logic [15:0]           peak_freq_q;
    logic                  new_peak;
    logic [15:0]           cap_peak_cur;
    logic [15:0]           cap_peak_freq;
    logic [15:0]           cur_res;
    ftr_pkg::ftr_word_t    state_word;

    // Read mux
    logic [31:0]           rd_mux;

    // Slave never stalls and never errors
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = rdata_q;
    assign fault_capture = capture;

    // Address phase qualifier, word index
    assign a_valid = hsel & hready & htrans[`FTR_HTRANS_NONSEQ];
    assign a_idx   = haddr[`FTR_IDX_MSB:`FTR_IDX_LSB];

    // A new fault is the rising edge of the active flag
    assign capture = fault_active & ~fault_prev_q;

    // Status word packed from live flags in the documented bit order
    always_comb
    begin
        state_word                    = `FTR_WORD_RESET;
        state_word[`FTR_ST_RUN]       = live.flags.running;
        state_word[`FTR_ST_ZERO_SPD]  = live.flags.zero_speed;
        state_word[`FTR_ST_DOWN]      = live.flags.down_dir;
        state_word[`FTR_ST_RST_IN]    = live.flags.reset_input;
        state_word[`FTR_ST_SPD_AGREE] = live.flags.speed_agree;
        state_word[`FTR_ST_READY]     = live.flags.ready;
        state_word[`FTR_ST_ALARM]     = live.flags.alarm;
        state_word[`FTR_ST_FAULT]     = live.flags.fault;
    end

    // Current resolution fixed by model; input always arrives in 0.01 A
    assign cur_res = COARSE_CURRENT ? 16'(live.out_current / `FTR_CUR_DIV)
                                    : live.out_current;

    // Peak includes the sample of the fault cycle itself
    assign new_peak      = live.out_current > peak_cur_q;
    assign cap_peak_cur  = new_peak ? live.out_current : peak_cur_q;
    assign cap_peak_freq = new_peak ? live.out_freq : peak_freq_q;

    // Fault edge detector
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fault_prev_q <= 1'b0;
        else
            fault_prev_q <= fault_active;
    end

    // Active and last fault codes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            active_code_q <= `FTR_WORD_RESET;
            last_code_q   <= `FTR_WORD_RESET;
        end
        else
        begin
            active_code_q <= fault_active ? fault_code : `FTR_WORD_RESET;
            if (capture)
                last_code_q <= fault_code;
        end
    end

    // Peak hold restarts with each ride and after each capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            peak_cur_q  <= `FTR_WORD_RESET;
            peak_freq_q <= `FTR_WORD_RESET;
        end
        else if (capture || ride_start)
        begin
            peak_cur_q  <= `FTR_WORD_RESET;
            peak_freq_q <= `FTR_WORD_RESET;
        end
        else if (new_peak)
        begin
            peak_cur_q  <= live.out_current;
            peak_freq_q <= live.out_freq;
        end
    end

    // Whole snapshot loads in one edge so values stay mutually consistent
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            snap_q <= '0;
        else if (capture)
        begin
            snap_q.speed_ref    <= live.speed_ref;
            snap_q.out_speed    <= live.out_speed;
            snap_q.motor_speed  <= live.motor_speed;
            snap_q.out_current  <= cur_res;
            snap_q.out_voltage  <= live.out_voltage;
            snap_q.bus_voltage  <= live.bus_voltage;
            snap_q.out_power    <= live.out_power;
            snap_q.torque_ref   <= live.torque_ref;
            snap_q.in_terms     <= live.in_terms;
            snap_q.out_terms    <= live.out_terms;
            snap_q.drive_state  <= state_word;
            snap_q.op_hours     <= live.op_hours;
            snap_q.soft_start   <= live.soft_start;
            snap_q.q_current    <= live.q_current;
            snap_q.d_current    <= live.d_current;
            snap_q.heatsink     <= live.heatsink;
            snap_q.peak_current <= cap_peak_cur;
            snap_q.peak_freq    <= cap_peak_freq;
        end
    end

    // History shift register: slot 0 newest, last slot falls off
    // Head and tail split at elaboration, so no slot indexes below zero
    genvar gi;
    generate
        for (gi = 0; gi < `FTR_HIST_DEPTH; gi++)
        begin : g_hist
            if (gi == 0)
            begin : g_code_head
                // Newest slot takes the code of the fault being captured
                always_ff @(posedge hclk or negedge hresetn)
                begin
                    if (!hresetn)
                        hist_code_q[gi] <= `FTR_WORD_RESET;
                    else if (capture)
                        hist_code_q[gi] <= fault_code;
                end
            end
            else
            begin : g_code_tail
                // Older slots take their younger neighbour
                always_ff @(posedge hclk or negedge hresetn)
                begin
                    if (!hresetn)
                        hist_code_q[gi] <= `FTR_WORD_RESET;
                    else if (capture)
                        hist_code_q[gi] <= hist_code_q[gi - 1];
                end
            end
            // Hours ride along with the four newest codes only
            if (gi == 0)
            begin : g_hrs_head
                always_ff @(posedge hclk or negedge hresetn)
                begin
                    if (!hresetn)
                        hist_hrs_q[gi] <= `FTR_WORD_RESET;
                    else if (capture)
                        hist_hrs_q[gi] <= live.op_hours;
                end
            end
            else if (gi < `FTR_HRS_DEPTH)
            begin : g_hrs_tail
                always_ff @(posedge hclk or negedge hresetn)
                begin
                    if (!hresetn)
                        hist_hrs_q[gi] <= `FTR_WORD_RESET;
                    else if (capture)
                        hist_hrs_q[gi] <= hist_hrs_q[gi - 1];
                end
            end
        end
    endgenerate

    // Count of valid history entries, saturates at full depth
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hist_cnt_q <= '0;
        else if (capture && hist_cnt_q != `FTR_HIST_FULL)
            hist_cnt_q <= hist_cnt_q + 1'b1;
    end

    // Apply display unit scaling; other codes show the raw value
    function automatic logic [15:0] ftr_scale(input logic [15:0] raw);
        logic [31:0] prod;
        prod = 32'h0;
        unique case (unit_sel_q)
            `FTR_UNIT_MPS_A,
            `FTR_UNIT_MPS_B: prod = raw * scale_mps_q;
            `FTR_UNIT_FPM:   prod = raw * scale_fpm_q;
            default:         prod = {raw, 15'h0000, 1'b0} >> 1;
        endcase
        return prod[`FTR_SCALE_MSB:`FTR_SCALE_LSB];
    endfunction : ftr_scale

    // Read decode; unmapped indices read as zero
    always_comb
    begin
        rd_mux = `FTR_BUS_ZERO;
        if (a_idx >= `FTR_IDX_HIST_A_LO && a_idx <= `FTR_IDX_HIST_A_HI)
            rd_mux[15:0] = hist_code_q[4'(a_idx - `FTR_IDX_HIST_A_LO)];
        else if (a_idx >= `FTR_IDX_HIST_B_LO && a_idx <= `FTR_IDX_HIST_B_HI)
            rd_mux[15:0] = hist_code_q[4'(a_idx - `FTR_IDX_HIST_B_LO)];
        else if (a_idx >= `FTR_IDX_HRS_A_LO && a_idx <= `FTR_IDX_HRS_A_HI)
            rd_mux[15:0] = hist_hrs_q[2'(a_idx - `FTR_IDX_HRS_A_LO)];
        else if (a_idx >= `FTR_IDX_HRS_B_LO && a_idx <= `FTR_IDX_HRS_B_HI)
            rd_mux[15:0] = hist_hrs_q[2'(a_idx - `FTR_IDX_HRS_B_LO)];
        else
        begin
            case (a_idx)
                `FTR_IDX_ACTIVE:     rd_mux[15:0] = active_code_q;
                `FTR_IDX_LAST:       rd_mux[15:0] = last_code_q;
                `FTR_IDX_SPD_REF:    rd_mux[15:0] = ftr_scale(snap_q.speed_ref);
                `FTR_IDX_OUT_SPD:    rd_mux[15:0] = ftr_scale(snap_q.out_speed);
                `FTR_IDX_OUT_CUR:    rd_mux[15:0] = snap_q.out_current;
                `FTR_IDX_MOT_SPD:    rd_mux[15:0] = ftr_scale(snap_q.motor_speed);
                `FTR_IDX_OUT_VOLT:   rd_mux[15:0] = snap_q.out_voltage;
                `FTR_IDX_BUS_VOLT:   rd_mux[15:0] = snap_q.bus_voltage;
                `FTR_IDX_OUT_PWR:    rd_mux[15:0] = snap_q.out_power;
                `FTR_IDX_TRQ_REF:    rd_mux[15:0] = snap_q.torque_ref;
                `FTR_IDX_IN_TERM:    rd_mux[15:0] = snap_q.in_terms;
                `FTR_IDX_OUT_TERM:   rd_mux[15:0] = snap_q.out_terms;
                `FTR_IDX_DRV_STATE:  rd_mux[15:0] = snap_q.drive_state;
                `FTR_IDX_OP_HOURS:   rd_mux[15:0] = snap_q.op_hours;
                `FTR_IDX_HEATSINK:   rd_mux[15:0] = snap_q.heatsink;
                `FTR_IDX_SOFT_START: rd_mux[15:0] = ftr_scale(snap_q.soft_start);
                `FTR_IDX_Q_CUR:      rd_mux[15:0] = snap_q.q_current;
                `FTR_IDX_D_CUR:      rd_mux[15:0] = snap_q.d_current;
                `FTR_IDX_PEAK_CUR:   rd_mux[15:0] = snap_q.peak_current;
                `FTR_IDX_PEAK_FREQ:  rd_mux[15:0] = snap_q.peak_freq;
                `FTR_IDX_CTRL:       rd_mux[2:0]  = unit_sel_q;
                `FTR_IDX_SCALE_MPS:  rd_mux[15:0] = scale_mps_q;
                `FTR_IDX_SCALE_FPM:  rd_mux[15:0] = scale_fpm_q;
                `FTR_IDX_STATUS:     rd_mux[4:0]  = {fault_active, hist_cnt_q};
                default:             rd_mux       = `FTR_BUS_ZERO;
            endcase
        end
    end

    // Read data loads at the address phase so it stands through the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= `FTR_BUS_ZERO;
        else if (a_valid && !hwrite)
            rdata_q <= rd_mux;
    end

    // Write address is held for the following data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= '0;
        end
        else if (hready)
        begin
            wr_pend_q <= a_valid & hwrite;
            wr_idx_q  <= a_idx;
        end
    end

    // Only the unit control registers take writes; all others drop them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            unit_sel_q  <= `FTR_UNIT_RESET;
            scale_mps_q <= `FTR_SCALE_RESET;
            scale_fpm_q <= `FTR_SCALE_RESET;
        end
        else if (wr_pend_q)
        begin
            case (wr_idx_q)
                `FTR_IDX_CTRL:      unit_sel_q  <= hwdata[2:0];
                `FTR_IDX_SCALE_MPS: scale_mps_q <= hwdata[15:0];
                `FTR_IDX_SCALE_FPM: scale_fpm_q <= hwdata[15:0];
                default:            unit_sel_q  <= unit_sel_q;
            endcase
        end
    end

endmodule : ftr_recorder

`default_nettype wire

// [verification/ftr_recorder_sva.sv]
// Purpose: Bus and capture assertions for the fault trace recorder.
// Assumes: Zero wait state slave; read data stands one cycle after its address.
// Notes:   Helper flops mirror the active code and what one capture must store.
`default_nettype none

module ftr_recorder_sva #(
    parameter logic COARSE_CURRENT = 1'b0
) (
    // Clock and reset
    input wire logic               hclk,
    input wire logic               hresetn,
    // Bus
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [2:0]         hsize,
    input wire logic [31:0]        hwdata,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic [31:0]        hrdata,
    // Drive side
    input wire logic               fault_active,
    input wire logic [15:0]        fault_code,
    input wire logic               ride_start,
    input wire ftr_pkg::ftr_live_s live,
    input wire logic               fault_capture
);
    logic [15:0] act_q, last_q, prev_q, hrs_q, heat_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Mirror of the capture; the active code follows every cycle, the rest move only on a real rising fault
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            act_q  <= 16'h0000;
            last_q <= 16'h0000;
            prev_q <= 16'h0000;
            hrs_q  <= 16'h0000;
            heat_q <= 16'h0000;
        end
        else
        begin
            act_q <= fault_active ? fault_code : 16'h0000;
            if (fault_capture)
            begin
                last_q <= fault_code;
                prev_q <= last_q;
                hrs_q  <= live.op_hours;
                heat_q <= live.heatsink;
            end
        end
    end

    // Read taken outside a capture cycle, so the stored value is settled
    sequence s_rd(logic [11:0] i);
        hsel && hready && htrans[1] && !hwrite && haddr[13:2] == i && !fault_capture;
    endsequence
    property p_rd(logic [11:0] i, logic [15:0] v);
        s_rd(i) |=> hrdata == {16'h0000, v};
    endproperty

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_capture_edge: assert property (fault_capture == (fault_active &&
        !($past(fault_active) && $past(hresetn)))) else $error("capture pulse wrong");
    a_active_read: assert property (p_rd(12'h080, $past(act_q)))
        else $error("active code wrong");
    a_last_read: assert property (p_rd(12'h081, last_q))
        else $error("last code wrong");
    a_newest_slot: assert property (p_rd(12'h090, last_q))
        else $error("newest slot wrong");
    a_alias_slot: assert property (p_rd(12'h800, last_q))
        else $error("alias slot wrong");
    a_shift_slot: assert property (p_rd(12'h091, prev_q))
        else $error("second slot wrong");
    a_hours_slot: assert property (p_rd(12'h094, hrs_q))
        else $error("newest hours wrong");
    a_heat_snap: assert property (p_rd(12'h08e, heat_q))
        else $error("heatsink snapshot wrong");
endmodule : ftr_recorder_sva

bind ftr_recorder ftr_recorder_sva #(.COARSE_CURRENT(COARSE_CURRENT)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fault_active(fault_active),
    .fault_code(fault_code), .ride_start(ride_start), .live(live),
    .fault_capture(fault_capture));

`default_nettype wire

// [verification/ftr_recorder_test.sv]
// Purpose: Self-checking bench for the fault trace recorder.
// Assumes: Zero wait state bus; hready looped back from hreadyout.
// Notes:   Each fault pulses ride_start to clear the peak, so the peak hold result is predictable.
`default_nettype none

module ftr_recorder_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata, rd_v;
    logic [1:0]         htrans = 2'h0;
    logic               hreadyout, hresp, fault_capture;
    logic               fault_active = 1'b0, ride_start = 1'b0;
    logic [15:0]        fault_code = 16'h0, b;
    ftr_pkg::ftr_live_s live = '0;
    int                 fails = 0, n_compared = 0;
    logic [11:0]        tbl [15] = '{12'h082, 12'h083, 12'h084, 12'h085, 12'h086,
        12'h087, 12'h088, 12'h089, 12'h08a, 12'h08b, 12'h08d, 12'h08e, 12'h7e0,
        12'h7e1, 12'h7e2};

    // Free running 40 MHz clock
    always #12.5 hclk = ~hclk;

    ftr_recorder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .fault_active(fault_active), .fault_code(fault_code), .ride_start(ride_start),
        .live(live), .fault_capture(fault_capture));

    task final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // Bounded wait for hready; a hang ends the run as a mismatch
    task wait_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1)
        begin
            fails++;
            final_report;
        end
    endtask : wait_rdy

    task bus(input logic [11:0] i, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {18'h00000, i, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        rd_v = hrdata;
    endtask : bus

    task rd(input logic [11:0] i, input logic [15:0] e);
        bus(i, 1'b0, 32'h0);
        n_compared++;
        if (rd_v !== {16'h0000, e})
        begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, rd_v, {16'h0000, e});
        end
    endtask : rd

    // Field k of a live sample is base plus k; flags come from the base
    function automatic ftr_pkg::ftr_live_s mk(input logic [15:0] s);
        logic [263:0] v;
        for (int k = 0; k < 16; k++)
            v[263-16*k -: 16] = s + 16'(k);
        v[7:0] = s[11:4];
        return v;
    endfunction : mk

    function automatic logic [15:0] scl(input logic [15:0] r, input logic [2:0] u);
        logic [31:0] m;
        m = {16'h0000, r} * ((u == 3'h6) ? 32'h0000c000 : 32'h00004000);
        return (u == 3'h0) ? r : m[30:15];
    endfunction : scl

    // Peak cleared, one pre-fault sample p, then the fault with sample s
    task fault(input logic [15:0] c, input logic [15:0] s, input logic [15:0] p);
        ride_start <= 1'b1;
        @(posedge hclk);
        ride_start <= 1'b0;
        live <= mk(p);
        @(posedge hclk);
        live <= mk(s);
        fault_active <= 1'b1;
        fault_code <= c;
        @(posedge hclk);
        fault_code <= ~c; // Late code change must not reach the history
        rd(12'h080, c);
        fault_active <= 1'b0;
        @(posedge hclk);
    endtask : fault

    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(12'h809, 16'h0000);
        for (int i = 1; i < 12; i++)
        begin
            b = 16'(i << 8);
            fault(16'h0010 + 16'(i), b, (i == 11) ? b + 16'h0040 : b - 16'h0010);
            if (i == 3)
            begin
                for (int j = 0; j < 4; j++)
                    rd(12'h800 + 12'(j), (j < 3) ? 16'h0013 - 16'(j) : 16'h0000);
                bus(12'h081, 1'b1, 32'h0000ffff);
                bus(12'h090, 1'b1, 32'h0000ffff);
                rd(12'h081, 16'h0013);
                rd(12'h090, 16'h0013);
                rd(12'h7ff, 16'h0000);
            end
        end
        // Oldest code dropped after eleven faults, hours follow the codes
        for (int j = 0; j < 10; j++)
            rd(12'h800 + 12'(j), 16'h001b - 16'(j));
        for (int j = 0; j < 4; j++)
        begin
            rd(12'h090 + 12'(j), 16'h001b - 16'(j));
            rd(12'h094 + 12'(j), 16'(((11 - j) << 8) + 10));
            rd(12'h80a + 12'(j), 16'(((11 - j) << 8) + 10));
        end
        for (int k = 0; k < 15; k++)
            rd(tbl[k], 16'h0b00 + 16'(k));
        // Flags run, down and reset input set; bit 0 is running
        rd(12'h08c, 16'h000d);
        rd(12'h7e6, 16'h0b42);
        rd(12'h7e7, 16'h0b4f);
        rd(12'h080, 16'h0000);
        rd(12'h7f3, 16'h000a);
        bus(12'h7f1, 1'b1, 32'h00004000);
        bus(12'h7f2, 1'b1, 32'h0000c000);
        // Display unit codes 0, 4, 5 and 6 against the four speed type values
        for (int u = 3; u < 7; u++)
        begin
            bus(12'h7f0, 1'b1, (u == 3) ? 32'h0 : 32'(u));
            for (int q = 0; q < 4; q++)
                rd(tbl[(q == 3) ? 12 : (q == 2) ? 3 : q],
                    scl(16'h0b00 + 16'((q == 3) ? 12 : (q == 2) ? 3 : q),
                    (u == 3) ? 3'h0 : 3'(u)));
        end
        final_report;
    end
endmodule : ftr_recorder_test

`default_nettype wire
